/* File: pkg/ext_irq_pkg.sv */
// package: register map, field layout and reset values of the external pin interrupt unit
// assumes: word-addressed avalon-mm slave, register index times four is the byte address
package ext_irq_pkg;
  // ---------------------------------------------------------------
  // register indices (byte address = index * 4)
  // ---------------------------------------------------------------
  localparam logic [7:0] SENSE_CONTROL_IDX = 8'h69;
  localparam logic [7:0] GROUP_ENABLE_IDX = 8'h68;
  localparam logic [7:0] GROUP0_MASK_IDX = 8'h6B;
  localparam logic [7:0] GROUP1_MASK_IDX = 8'h6C;
  localparam logic [7:0] GROUP2_MASK_IDX = 8'h6D;
  localparam logic [7:0] GROUP3_MASK_IDX = 8'h73;
  localparam logic [7:0] EXT_ENABLE_IDX = 8'h3D;
  localparam logic [7:0] EXT_FLAGS_IDX = 8'h3C;
  localparam logic [7:0] GROUP_FLAGS_IDX = 8'h3B;
  localparam logic [7:0] CORE_CONTROL_IDX = 8'h3F;
  // ---------------------------------------------------------------
  // fields and reset values
  // ---------------------------------------------------------------
  localparam int EXT_PINS = 3;
  localparam int GROUPS = 4;
  localparam int GROUP_WIDTH = 8;
  localparam int SENSE_WIDTH = 6;
  localparam int GLOBAL_ENABLE_BIT = 0;
  localparam int SLEEP_BIT = 1;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [2:0] EXT_IDLE_LEVEL = 3'h7;
  localparam logic [2:0] BUFFER_RESET = 3'h7;
  localparam logic [1:0] SENSE_LOW_LEVEL = 2'h0;
  localparam logic [1:0] SENSE_ANY_EDGE = 2'h1;
  localparam logic [1:0] SENSE_FALLING = 2'h2;
  localparam logic [1:0] SENSE_RISING = 2'h3;
  localparam int SYNC_STAGES = 2;
endpackage : ext_irq_pkg

/* File: hw/pin_event_sync.sv */
// holds a two-stage synchroniser for a bundle of pin levels
// assumes: inputs are asynchronous to ref_clk; only the second stage is read outside
`timescale 1ns/1ps
`default_nettype none
module pin_event_sync #(
  parameter int WIDTH = 8
) (
  input wire logic ref_clk, // unit clock
  input wire logic rst_n, // async reset, active low
  input wire logic [WIDTH-1:0] asyncIn, // raw pin levels
  output logic [WIDTH-1:0] syncOut // levels in the clock domain
);
  logic [WIDTH-1:0] stage1;

  // ---------------------------------------------------------------
  // two flops; first stage feeds only the second
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1 <= '0;
      syncOut <= '0;
    end else begin
      stage1 <= asyncIn;
      syncOut <= stage1;
    end
  end
endmodule : pin_event_sync
`default_nettype wire

/* File: hw/external_pin_interrupt_unit.sv */
// holds the external pin interrupt unit: three sensed request pins, four change groups
// assumes: avalon-mm master on ref_clk; the core acknowledges serviced requests by pulses
//
// Operation
// RQ1 - requests come from pin levels, whatever the pin direction is.
// RQ2 - four group requests, each from toggles of its eight enabled pins.
// RQ3 - only pins set in the group mask contribute to the group request.
// RQ4 - pin changes are caught without the clock so they can wake sleep; here they are sampled on ref_clk edges only.
// RQ5 - group flags are set only while the unit clock runs.
// RQ6 - a toggle that reverts before wake completes raises no flag.
// RQ7 - two sense bits per request pin: low, any edge, falling, rising.
// RQ8 - low-level sensing requests for as long as the pin stays low.
// RQ9 - level and edge conditions are caught without the clock for wake; here both are sampled on ref_clk edges only.
// RQ10 - a waking source holds its level through the whole start-up time.
// RQ11 - a level source holds low until the current instruction ends.
// RQ12 - pulses wider than the minimum width always raise a request.
// RQ13 - sense control bits 7:6 read zero.
// RQ14 - software disables, changes sense, clears flag, then re-enables.
// RQ15 - a pin request is enabled by its mask bit and the global enable.
// RQ16 - edge flags set on trigger, clear on service or written one.
// RQ17 - a flag stays clear while its pin uses low-level sensing.
// RQ18 - sleep with a request disabled gates its input; flags may set.
// RQ19 - group enable register holds bits 3:0, upper bits read zero.
// RQ20 - group 3 flag sets on a change and clears on service or one.
// RQ21 - groups 2, 1, 0 flags behave like group 3 in bits 2:0.
// RQ22 - four eight-bit group masks reset to zero.
// RQ23 - pin events pass a synchroniser before setting any flag, once each.
//
// Added by the designer: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module external_pin_interrupt_unit #(
  parameter int EXT_COUNT = ext_irq_pkg::EXT_PINS,
  parameter int GROUP_COUNT = ext_irq_pkg::GROUPS
) (
  input wire logic ref_clk, // 50 MHz unit clock
  input wire logic rst_n, // async reset, active low
  input wire logic [9:0] avs_address, // word address
  input wire logic avs_read, // read request
  input wire logic avs_write, // write request
  input wire logic [31:0] avs_writedata, // write data
  input wire logic [3:0] avs_byteenable, // byte lanes
  output logic [31:0] avs_readdata, // read data
  output logic avs_waitrequest, // high until answer
  input wire logic [2:0] ext_request_pins, // external request pins
  input wire logic [31:0] change_watch_pins, // pin-change pins
  input wire logic [2:0] ext_service_ack, // core serviced ext request n, pulse
  input wire logic [3:0] group_service_ack, // core serviced group n, pulse
  output logic [2:0] ext_request, // enabled external requests to core
  output logic [3:0] change_group_request, // enabled group requests to core
  output logic [2:0] input_buffer_enable // per-pin input buffer on
);
  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [5:0] senseControl;
  logic [2:0] extEnable;
  logic [2:0] extFlags;
  logic [3:0] groupEnable;
  logic [3:0] groupFlags;
  logic [7:0] groupMask [GROUP_COUNT];
  logic globalEnable;
  logic sleepMode;
  logic busy;

  wire logic [7:0] regIdx = avs_address[7:0];
  wire logic hiZero = (avs_address[9:8] == 2'h0);
  // writes act at the answer edge, the one at which the master sees the answer
  wire logic wrLane0 = avs_write && avs_byteenable[0] && busy && hiZero;
  wire logic [7:0] wrByte = avs_writedata[7:0];

  // ---------------------------------------------------------------
  // input gating and synchronisation
  // ---------------------------------------------------------------
  // pins are read at the pad, so an output-driven pin still requests [RQ1]
  // gated buffers park at high; a change here may set an edge flag [RQ18]
  logic [2:0] gatedExt;
  always_comb begin
    gatedExt = ext_request_pins | ~input_buffer_enable;
  end

  logic [2:0] extSync;
  logic [31:0] pinSync;
  pin_event_sync #(.WIDTH(3)) extSyncInst (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .asyncIn(gatedExt),
    .syncOut(extSync)
  ); // [RQ23]
  pin_event_sync #(.WIDTH(32)) pinSyncInst (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .asyncIn(change_watch_pins),
    .syncOut(pinSync)
  ); // [RQ23]

  logic [2:0] extPrev;
  logic [31:0] pinPrev;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      extPrev <= ext_irq_pkg::EXT_IDLE_LEVEL;
      pinPrev <= '0;
    end else begin
      extPrev <= extSync;
      pinPrev <= pinSync;
    end
  end

  // ---------------------------------------------------------------
  // edge history
  // ---------------------------------------------------------------
  // sync stages and pinPrev reset to zero, extPrev to all ones, not to the pin levels; edges
  // count only once all of them hold real samples, so reset fakes none
  logic [1:0] histCount;
  logic histValid;
  always_comb begin
    histValid = (histCount == 2'(ext_irq_pkg::SYNC_STAGES + 1));
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      histCount <= 2'h0;
    end else if (!histValid) begin
      histCount <= histCount + 2'h1;
    end
  end

  // ---------------------------------------------------------------
  // external pin sensing
  // ---------------------------------------------------------------
  // detection is level compare across clocked samples; any pulse longer than
  // one clock period is seen, shorter pulses may be missed [RQ12]
  logic [2:0] extTrigger;
  logic [2:0] extLevelLow;
  always_comb begin
    extTrigger = '0;
    extLevelLow = '0;
    for (int n = 0; n < EXT_COUNT; n++) begin
      case (senseControl[2*n +: 2]) // [RQ7]
        ext_irq_pkg::SENSE_LOW_LEVEL: extLevelLow[n] = !extSync[n]; // [RQ8]
        ext_irq_pkg::SENSE_ANY_EDGE: extTrigger[n] = extSync[n] ^ extPrev[n];
        ext_irq_pkg::SENSE_FALLING: extTrigger[n] = extPrev[n] && !extSync[n];
        ext_irq_pkg::SENSE_RISING: extTrigger[n] = !extPrev[n] && extSync[n];
        default: extTrigger[n] = 1'b0;
      endcase
      extTrigger[n] = extTrigger[n] && histValid;
      extLevelLow[n] = extLevelLow[n] && histValid;
    end
  end

  // ---------------------------------------------------------------
  // pin-change sensing per group
  // ---------------------------------------------------------------
  // level compare means a toggle that reverts before the clock restarts
  // leaves no difference and so raises no flag [RQ4] [RQ5] [RQ6]
  logic [3:0] groupTrigger;
  genvar g;
  generate
    for (g = 0; g < GROUP_COUNT; g++) begin : groupGen
      wire logic [7:0] toggled = pinSync[8*g +: 8] ^ pinPrev[8*g +: 8];
      assign groupTrigger[g] = histValid && |(toggled & groupMask[g]); // [RQ2] [RQ3]
    end
  endgenerate

  // ---------------------------------------------------------------
  // flags: hardware set wins over clear
  // ---------------------------------------------------------------
  logic [2:0] extClear;
  logic [3:0] groupClear;
  always_comb begin
    extClear = ext_service_ack;
    groupClear = group_service_ack;
    if (wrLane0 && regIdx == ext_irq_pkg::EXT_FLAGS_IDX) begin
      extClear = extClear | wrByte[2:0];
    end
    if (wrLane0 && regIdx == ext_irq_pkg::GROUP_FLAGS_IDX) begin
      groupClear = groupClear | wrByte[3:0];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      extFlags <= '0;
    end else begin
      for (int n = 0; n < EXT_COUNT; n++) begin
        if (senseControl[2*n +: 2] == ext_irq_pkg::SENSE_LOW_LEVEL) begin
          extFlags[n] <= 1'b0; // [RQ17]
        end else if (extTrigger[n]) begin
          extFlags[n] <= 1'b1; // [RQ16]
        end else if (extClear[n]) begin
          extFlags[n] <= 1'b0; // [RQ16]
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      groupFlags <= '0;
    end else begin
      groupFlags <= groupTrigger | (groupFlags & ~groupClear); // [RQ20] [RQ21]
    end
  end

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      senseControl <= '0;
    end else if (wrLane0 && regIdx == ext_irq_pkg::SENSE_CONTROL_IDX) begin
      senseControl <= wrByte[5:0]; // [RQ7]
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      extEnable <= '0;
    end else if (wrLane0 && regIdx == ext_irq_pkg::EXT_ENABLE_IDX) begin
      extEnable <= wrByte[2:0]; // [RQ15]
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      groupEnable <= '0;
    end else if (wrLane0 && regIdx == ext_irq_pkg::GROUP_ENABLE_IDX) begin
      groupEnable <= wrByte[3:0]; // [RQ19]
    end
  end

  // ---------------------------------------------------------------
  // core control: global enable and sleep
  // ---------------------------------------------------------------
  // stands in for the status word and sleep logic that sit outside this unit
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      globalEnable <= 1'b0;
      sleepMode <= 1'b0;
    end else if (wrLane0 && regIdx == ext_irq_pkg::CORE_CONTROL_IDX) begin
      globalEnable <= wrByte[ext_irq_pkg::GLOBAL_ENABLE_BIT];
      sleepMode <= wrByte[ext_irq_pkg::SLEEP_BIT];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < GROUP_COUNT; i++) begin
        groupMask[i] <= ext_irq_pkg::REG_RESET; // [RQ22]
      end
    end else if (wrLane0) begin
      case (regIdx)
        ext_irq_pkg::GROUP0_MASK_IDX: groupMask[0] <= wrByte; // [RQ22]
        ext_irq_pkg::GROUP1_MASK_IDX: groupMask[1] <= wrByte;
        ext_irq_pkg::GROUP2_MASK_IDX: groupMask[2] <= wrByte;
        ext_irq_pkg::GROUP3_MASK_IDX: groupMask[3] <= wrByte;
        default: begin
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // requests to the core
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_request <= '0;
    end else begin
      for (int n = 0; n < EXT_COUNT; n++) begin
        ext_request[n] <= extEnable[n] && globalEnable && // [RQ15]
          (extFlags[n] || extLevelLow[n]); // [RQ8] [RQ9]
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      change_group_request <= '0;
    end else begin
      change_group_request <= groupFlags & groupEnable & {4{globalEnable}}; // [RQ19]
    end
  end

  // ---------------------------------------------------------------
  // input buffers
  // ---------------------------------------------------------------
  // only a disabled pin loses its buffer, so an enabled one can still wake
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      input_buffer_enable <= ext_irq_pkg::BUFFER_RESET;
    end else begin
      for (int n = 0; n < EXT_COUNT; n++) begin
        input_buffer_enable[n] <= !sleepMode || extEnable[n]; // [RQ18]
      end
    end
  end

  // ---------------------------------------------------------------
  // avalon-mm slave: one wait cycle, then answer
  // ---------------------------------------------------------------
  logic [7:0] readByte;
  always_comb begin
    readByte = 8'h00;
    case (regIdx)
      ext_irq_pkg::SENSE_CONTROL_IDX: readByte = {2'h0, senseControl}; // [RQ13]
      ext_irq_pkg::EXT_ENABLE_IDX: readByte = {5'h00, extEnable};
      ext_irq_pkg::EXT_FLAGS_IDX: readByte = {5'h00, extFlags};
      ext_irq_pkg::GROUP_ENABLE_IDX: readByte = {4'h0, groupEnable}; // [RQ19]
      ext_irq_pkg::GROUP_FLAGS_IDX: readByte = {4'h0, groupFlags};
      ext_irq_pkg::GROUP0_MASK_IDX: readByte = groupMask[0];
      ext_irq_pkg::GROUP1_MASK_IDX: readByte = groupMask[1];
      ext_irq_pkg::GROUP2_MASK_IDX: readByte = groupMask[2];
      ext_irq_pkg::GROUP3_MASK_IDX: readByte = groupMask[3];
      ext_irq_pkg::CORE_CONTROL_IDX: readByte = {6'h00, sleepMode, globalEnable};
      default: readByte = 8'h00;
    endcase
    if (!hiZero) begin
      readByte = 8'h00;
    end
  end

  // ---------------------------------------------------------------
  // handshake
  // ---------------------------------------------------------------
  // busy marks the answer cycle; writes act there, reads latch the edge before
  wire logic takeReq = (avs_read || avs_write) && avs_waitrequest && !busy;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b0;
      avs_waitrequest <= 1'b1;
    end else begin
      busy <= takeReq;
      avs_waitrequest <= !takeReq;
    end
  end

  // data latched one edge early stand through the whole answer cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && takeReq) begin
      avs_readdata <= {24'h00_0000, readByte};
    end
  end
endmodule : external_pin_interrupt_unit
`default_nettype wire

/* File: test/pin_source_model.sv */
// holds the model of the external sources driving request and change pins
// assumes: the bench calls drive right after a rising ref_clk edge
`timescale 1ns/1ps
`default_nettype none
module pin_source_model (
  input wire logic ref_clk, // unit clock
  output logic [2:0] extPins, // request pin levels
  output logic [31:0] watchPins // change pin levels
);
  initial begin
    extPins = 3'h7;
    watchPins = 32'h0;
  end
  // levels are held the whole span so a waking device still finds them
  task automatic drive(input logic [2:0] e, input logic [31:0] w, input int hold);
    extPins <= e;
    watchPins <= w;
    repeat (hold) @(posedge ref_clk);
  endtask : drive
endmodule : pin_source_model
`default_nettype wire

/* File: test/ext_irq_sva.sv */
// holds the checker for bus timing, reserved bits and request behaviour
// assumes: bound into external_pin_interrupt_unit, one ref_clk domain
`timescale 1ns/1ps
`default_nettype none
module ext_irq_sva (
  input wire logic ref_clk, // unit clock
  input wire logic rst_n, // async reset
  input wire logic [9:0] avs_address, // word address
  input wire logic avs_read, // read request
  input wire logic avs_write, // write request
  input wire logic [31:0] avs_readdata, // read data
  input wire logic avs_waitrequest, // answer strobe
  input wire logic [3:0] group_service_ack, // group serviced
  input wire logic [31:0] change_watch_pins, // change pins
  input wire logic [2:0] ext_request, // ext requests
  input wire logic [3:0] change_group_request, // group requests
  input wire logic [2:0] input_buffer_enable // buffers on
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence s_taken;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_answer(logic [7:0] idx);
    avs_read && !avs_waitrequest && avs_address == {2'b00, idx};
  endsequence
  a_answer_next: assert property (s_taken |=> !avs_waitrequest)
    else $error("request not answered in the next cycle");
  a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("answer strobe longer than one cycle");
  a_data_upper: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
    else $error("read data upper bytes not zero");
  a_sense_reserved: assert property (
    s_answer(ext_irq_pkg::SENSE_CONTROL_IDX) |-> avs_readdata[7:6] == 2'h0)
    else $error("sense control top bits not zero");
  a_enable_reserved: assert property (
    s_answer(ext_irq_pkg::GROUP_ENABLE_IDX) |-> avs_readdata[7:4] == 4'h0)
    else $error("group enable top bits not zero");
  a_flags_reserved: assert property (
    s_answer(ext_irq_pkg::GROUP_FLAGS_IDX) |-> avs_readdata[7:4] == 4'h0)
    else $error("group flags top bits not zero");
  a_reset_quiet: assert property ($rose(rst_n) |-> ext_request == 3'h0 &&
    change_group_request == 4'h0 && input_buffer_enable == 3'h7)
    else $error("outputs not at reset values");
  a_ack_drop: assert property (group_service_ack[0] &&
    change_watch_pins[7:0] == $past(change_watch_pins[7:0], 4) |-> ##2 !change_group_request[0])
    else $error("group request survives its service");
endmodule : ext_irq_sva
bind external_pin_interrupt_unit ext_irq_sva u_ext_irq_sva (.ref_clk(ref_clk), .rst_n(rst_n),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .group_service_ack(group_service_ack), .change_watch_pins(change_watch_pins),
  .ext_request(ext_request), .change_group_request(change_group_request),
  .input_buffer_enable(input_buffer_enable));
`default_nettype wire

/* File: test/external_pin_interrupt_unit_tb.sv */
// holds the self-checking bench: bus tasks, pin scenarios, read monitor
// assumes: one-cycle bus answers, request four edges after a pin change
`timescale 1ns/1ps
`default_nettype none
module external_pin_interrupt_unit_tb;
  logic ref_clk, rst_n, avs_read, avs_write, avs_waitrequest;
  logic [9:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, change_watch_pins;
  logic [3:0] avs_byteenable, group_service_ack, change_group_request;
  logic [2:0] ext_request_pins, ext_service_ack, ext_request, input_buffer_enable;
  logic [7:0] expQ[$];
  logic [3:0] byteLanes = 4'hF;
  int miscompares = 0;
  int testsRun = 0;
  // sense, group enable, masks of groups 0 to 3
  localparam logic [7:0] REG_IDX [6] = '{8'h69, 8'h68, 8'h6B, 8'h6C, 8'h6D, 8'h73};
  localparam logic [7:0] WMASK [6] = '{8'h3F, 8'h0F, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  external_pin_interrupt_unit u_external_pin_interrupt_unit (.ref_clk(ref_clk), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .ext_request_pins(ext_request_pins), .change_watch_pins(change_watch_pins),
    .ext_service_ack(ext_service_ack), .group_service_ack(group_service_ack),
    .ext_request(ext_request), .change_group_request(change_group_request),
    .input_buffer_enable(input_buffer_enable));
  pin_source_model src (.ref_clk(ref_clk), .extPins(ext_request_pins),
    .watchPins(change_watch_pins));
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    testsRun++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // extra edge at the end keeps the next request off the release time step
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d, input logic [7:0] e);
    avs_address <= {2'b00, a};
    avs_writedata <= {24'h0, d};
    avs_byteenable <= byteLanes;
    avs_read <= !wr;
    avs_write <= wr;
    if (!wr) expQ.push_back(e);
    do begin
      @(posedge ref_clk);
    end while (avs_waitrequest !== 1'b0);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge ref_clk);
  endtask : bus
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", testsRun, miscompares);
    if (miscompares == 0 && testsRun > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : finish_test
  always @(posedge ref_clk) begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
      check(avs_readdata, {24'h0, expQ.pop_front()});
    end
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    miscompares++;
    finish_test();
  end
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    logic [7:0] d;
    logic fall, rise;
    rst_n = 1'b0;
    avs_address = 10'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    ext_service_ack = 3'h0;
    group_service_ack = 4'h0;
    void'($urandom(9621));
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    for (int i = 0; i < 6; i++) bus(1'b0, REG_IDX[i], 8'h00, 8'h00);
    for (int i = 0; i < 6; i++) begin
      d = 8'($urandom);
      bus(1'b1, REG_IDX[i], d, 8'h00);
      bus(1'b0, REG_IDX[i], 8'h00, d & WMASK[i]);
    end
    bus(1'b0, 8'hFF, 8'h00, 8'h00);
    bus(1'b1, ext_irq_pkg::CORE_CONTROL_IDX, 8'h01, 8'h00);
    bus(1'b1, ext_irq_pkg::GROUP_ENABLE_IDX, 8'h0F, 8'h00);
    byteLanes = 4'hE;
    bus(1'b1, ext_irq_pkg::GROUP_ENABLE_IDX, 8'h00, 8'h00);
    byteLanes = 4'hF;
    bus(1'b0, ext_irq_pkg::GROUP_ENABLE_IDX, 8'h00, 8'h0F);
    for (int g = 0; g < 4; g++) begin
      d = (8'($urandom) & 8'h7E) | 8'h01;
      bus(1'b1, REG_IDX[2 + g], d, 8'h00);
      src.drive(ext_request_pins, change_watch_pins ^ (32'h80 << (8 * g)), 6);
      check(change_group_request, 32'h0);
      src.drive(ext_request_pins, change_watch_pins ^ (32'h01 << (8 * g)), 6);
      check(change_group_request, {28'h0, 4'h1 << g});
      bus(1'b0, ext_irq_pkg::GROUP_FLAGS_IDX, 8'h00, 8'h01 << g);
      if (g == 0) group_service_ack <= 4'h1;
      else bus(1'b1, ext_irq_pkg::GROUP_FLAGS_IDX, 8'h01 << g, 8'h00);
      @(posedge ref_clk);
      group_service_ack <= 4'h0;
      repeat (2) @(posedge ref_clk);
      check(change_group_request, 32'h0);
    end
    for (int c = 0; c < 4; c++) begin
      fall = (c == 1 || c == 2);
      rise = (c == 1 || c == 3);
      bus(1'b1, ext_irq_pkg::EXT_ENABLE_IDX, 8'h00, 8'h00);
      bus(1'b1, ext_irq_pkg::SENSE_CONTROL_IDX, 8'(c), 8'h00);
      bus(1'b1, ext_irq_pkg::EXT_FLAGS_IDX, 8'h07, 8'h00);
      bus(1'b1, ext_irq_pkg::EXT_ENABLE_IDX, 8'h01, 8'h00);
      src.drive(3'h6, change_watch_pins, 6);
      check(ext_request, {31'h0, c == 0 || fall});
      bus(1'b0, ext_irq_pkg::EXT_FLAGS_IDX, 8'h00, {7'h0, fall});
      ext_service_ack <= 3'h1;
      @(posedge ref_clk);
      ext_service_ack <= 3'h0;
      src.drive(3'h7, change_watch_pins, 6);
      bus(1'b0, ext_irq_pkg::EXT_FLAGS_IDX, 8'h00, {7'h0, rise && c != 0});
    end
    bus(1'b1, ext_irq_pkg::CORE_CONTROL_IDX, 8'h00, 8'h00);
    repeat (2) @(posedge ref_clk);
    check(ext_request, 32'h0);
    bus(1'b1, ext_irq_pkg::CORE_CONTROL_IDX, 8'h02, 8'h00);
    repeat (2) @(posedge ref_clk);
    check(input_buffer_enable, 32'h1);
    bus(1'b1, ext_irq_pkg::CORE_CONTROL_IDX, 8'h00, 8'h00);
    repeat (2) @(posedge ref_clk);
    check(input_buffer_enable, 32'h7);
    finish_test();
  end
endmodule : external_pin_interrupt_unit_tb
`default_nettype wire
